// file: pcrc_cfg.svh
// constants for the programmable crc generator: offsets, fields, resets
// assumes a 16-bit register port with byte strobes and one system clock
//
// Notes on behaviour
// - length field holds polynomial length minus one
// - taps enable terms one to fifteen
// - constant term always, top term at length field plus one
// - fifo depth 8 above length 7, else 16
// - byte writes assembled until word top reached
// - count increments when word top byte written
// - shift only with go set and words queued
// - decrement after word lsb shifted, continue until zero
// - length plus one cycles per word
// - full flag when count reaches depth
// - empty flag at zero, resets to one
// - write while full wraps count, no interrupt
// - interrupt only on count one to zero
// - go bit starts and stops shifter
// - sleep freezes state, resumes afterwards
// - idle stop acts as sleep, events pass
// - count, full, empty in control register
`ifndef PCRC_CFG_SVH
`define PCRC_CFG_SVH

// ----------------------------------------------------------------
// register map
// ----------------------------------------------------------------
`define PCRC_ADDR_CONTROL 2'h0
`define PCRC_ADDR_TAPS 2'h1
`define PCRC_ADDR_DATA 2'h2
`define PCRC_ADDR_RESULT 2'h3

// ----------------------------------------------------------------
// control fields
// ----------------------------------------------------------------
`define PCRC_LEN_LSB 0
`define PCRC_LEN_MSB 3
`define PCRC_GO_BIT 4
`define PCRC_EMPTY_BIT 6
`define PCRC_FULL_BIT 7
`define PCRC_COUNT_LSB 8
`define PCRC_COUNT_MSB 12
`define PCRC_IDLE_BIT 13

// ----------------------------------------------------------------
// reset values and depths
// ----------------------------------------------------------------
`define PCRC_CONTROL_RESET 16'h0040
`define PCRC_TAPS_RESET 16'h0000
`define PCRC_SHORT_DEPTH 5'h10
`define PCRC_LONG_DEPTH 5'h08
`define PCRC_LEN_SPLIT 4'h7

`endif

// file: pcrc_pkg.sv
// types shared by the programmable crc generator files
// assumes pcrc_cfg.svh is compiled alongside
package pcrc_pkg;
  typedef enum logic [0:0] {
    PCRC_IDLE = 1'b0,
    PCRC_SHIFT = 1'b1
  } pcrc_state_t;
endpackage

// file: pcrc_word_store.sv
// word storage of the crc fifo, flip-flops addressed by index
// assumes caller keeps pointers in range and decides push and pop
`timescale 1ns/1ps
module pcrc_word_store #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 16
) (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic push,
  input wire logic [3:0] writeIndex,
  input wire logic [WIDTH-1:0] writeWord,
  input wire logic [3:0] readIndex,
  output logic [WIDTH-1:0] readWord
);
  logic [WIDTH-1:0] mem [DEPTH];

  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      for (int i = 0; i < DEPTH; i++)
      begin
        mem[i] <= '0;
      end
    end
    else if (push)
    begin
      mem[writeIndex] <= writeWord;
    end
  end

  assign readWord = mem[readIndex];
endmodule

// file: pcrc_engine.sv
// lfsr crc engine, one data bit per clock
// assumes shift is only raised while a word is being serialised
`timescale 1ns/1ps
`include "pcrc_cfg.svh"
module pcrc_engine (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic shift,
  input wire logic dataBit,
  input wire logic [3:0] polyLenMinusOne,
  input wire logic [15:0] taps,
  input wire logic load,
  input wire logic [15:0] loadValue,
  output logic [15:0] crcValue
);
  logic fb;
  logic [15:0] nextCrc;

  // ----------------------------------------------------------------
  // feedback network
  // ----------------------------------------------------------------
  always_comb
  begin
    fb = crcValue[polyLenMinusOne] ^ dataBit;
    nextCrc = '0;
    nextCrc[0] = fb;
    for (int i = 1; i < 16; i++)
    begin
      nextCrc[i] = crcValue[i-1] ^ (fb & taps[i]);
    end
    for (int i = 0; i < 16; i++)
    begin
      if (i > int'(polyLenMinusOne))
      begin
        nextCrc[i] = 1'b0;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      crcValue <= '0;
    end
    else if (load)
    begin
      crcValue <= loadValue;
    end
    else if (shift)
    begin
      crcValue <= nextCrc;
    end
  end
endmodule

// file: pcrc_top.sv
// programmable crc generator: registers, fifo control and serial shifter
// assumes synchronous register port, read data valid one cycle after strobe
//
// Design decisions made here: the plain strobed port and the placing of the registers.
`timescale 1ns/1ps
`include "pcrc_cfg.svh"
module pcrc_top (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic [1:0] regAddr,
  input wire logic [15:0] regWriteData,
  input wire logic [1:0] regByteEn,
  input wire logic regWrite,
  input wire logic regRead,
  input wire logic sleepReq,
  input wire logic idleReq,
  output logic [15:0] regReadData,
  output logic crcDone
);
  logic [3:0] polyLenMinusOne;
  logic shiftGo;
  logic stopInIdle;
  logic [15:0] taps;
  logic [4:0] validWordCount;
  logic fifoFullFlag;
  logic fifoEmptyFlag;
  logic [3:0] wrPtr;
  logic [3:0] rdPtr;
  logic [15:0] assembly;
  logic [15:0] headWord;
  logic [3:0] bitIndex;
  logic [15:0] crcValue;
  logic frozen;
  logic [4:0] depth;
  logic pushWord;
  logic popWord;
  logic shiftNow;
  logic dataWrite;
  logic [15:0] mergedWord;
  logic msbWritten;
  logic resultLoad;
  pcrc_pkg::pcrc_state_t state;
  pcrc_pkg::pcrc_state_t next_state;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // depth from length
  function automatic logic [4:0] depthOf(input logic [3:0] len);
    depthOf = (len > `PCRC_LEN_SPLIT) ? `PCRC_LONG_DEPTH : `PCRC_SHORT_DEPTH;
  endfunction

  function automatic logic [15:0] byteMerge(
    input logic [15:0] old,
    input logic [15:0] wdata,
    input logic [1:0] be
  );
    byteMerge = old;
    if (be[0])
    begin
      byteMerge[7:0] = wdata[7:0];
    end
    if (be[1])
    begin
      byteMerge[15:8] = wdata[15:8];
    end
  endfunction

  // ----------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------
  // sleep and idle-stop freeze everything but the register port
  assign frozen = sleepReq | (idleReq & stopInIdle);
  assign depth = depthOf(polyLenMinusOne);
  assign dataWrite = regWrite && (regAddr == `PCRC_ADDR_DATA);
  assign mergedWord = byteMerge(assembly, regWriteData, regByteEn);
  // word complete once its top byte lane is written
  assign msbWritten = dataWrite &&
    (polyLenMinusOne > `PCRC_LEN_SPLIT ? regByteEn[1] : regByteEn[0]);
  assign pushWord = msbWritten;
  // shift only with go and words
  assign shiftNow = !frozen && shiftGo && (validWordCount != 5'h00) &&
    (state == pcrc_pkg::PCRC_SHIFT);
  // length plus one bits per word
  assign popWord = shiftNow && (bitIndex == polyLenMinusOne);
  assign resultLoad = regWrite && (regAddr == `PCRC_ADDR_RESULT);

  // ----------------------------------------------------------------
  // control register
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      polyLenMinusOne <= 4'(`PCRC_CONTROL_RESET >> `PCRC_LEN_LSB);
    end
    else if (regWrite && regAddr == `PCRC_ADDR_CONTROL && regByteEn[0])
    begin
      polyLenMinusOne <= regWriteData[`PCRC_LEN_MSB:`PCRC_LEN_LSB];
    end
  end

  // hardware never clears go, so a drained fifo restarts on the next word
  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      shiftGo <= 1'b0;
    end
    else if (regWrite && regAddr == `PCRC_ADDR_CONTROL && regByteEn[0])
    begin
      shiftGo <= regWriteData[`PCRC_GO_BIT];
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      stopInIdle <= 1'b0;
    end
    else if (regWrite && regAddr == `PCRC_ADDR_CONTROL && regByteEn[1])
    begin
      stopInIdle <= regWriteData[`PCRC_IDLE_BIT];
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      taps <= `PCRC_TAPS_RESET;
    end
    else if (regWrite && regAddr == `PCRC_ADDR_TAPS)
    begin
      taps <= byteMerge(taps, regWriteData, regByteEn) & 16'hfffe;
    end
  end

  // ----------------------------------------------------------------
  // word assembly
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      assembly <= '0;
    end
    else if (dataWrite)
    begin
      assembly <= msbWritten ? 16'h0000 : mergedWord;
    end
  end

  // ----------------------------------------------------------------
  // fifo pointers and count
  // ----------------------------------------------------------------
  // pointers wrap at the live depth: changing length with words queued scrambles order
  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      wrPtr <= 4'h0;
    end
    else if (pushWord && fifoFullFlag)
    begin
      wrPtr <= 4'h0;
    end
    else if (pushWord)
    begin
      wrPtr <= (wrPtr + 4'h1) & 4'(depth - 5'h01);
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      rdPtr <= 4'h0;
    end
    else if (pushWord && fifoFullFlag)
    begin
      rdPtr <= 4'h0;
    end
    else if (popWord)
    begin
      rdPtr <= (rdPtr + 4'h1) & 4'(depth - 5'h01);
    end
  end

  // push and pop together leave the count alone unless full, where the push clears it
  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      validWordCount <= 5'h00;
    end
    else if (pushWord && fifoFullFlag)
    begin
      validWordCount <= 5'h00;
    end
    else if (pushWord && !popWord)
    begin
      validWordCount <= validWordCount + 5'h01;
    end
    else if (popWord && !pushWord)
    begin
      validWordCount <= validWordCount - 5'h01;
    end
  end

  assign fifoFullFlag = (validWordCount == depth);
  assign fifoEmptyFlag = (validWordCount == 5'h00);

  // ----------------------------------------------------------------
  // shifter state
  // ----------------------------------------------------------------
  always_comb
  begin
    next_state = state;
    unique case (state)
      pcrc_pkg::PCRC_IDLE:
      begin
        if (!frozen && shiftGo && validWordCount != 5'h00)
        begin
          next_state = pcrc_pkg::PCRC_SHIFT;
        end
      end
      pcrc_pkg::PCRC_SHIFT:
      begin
        if (!frozen && (!shiftGo || (popWord && validWordCount == 5'h01)))
        begin
          next_state = pcrc_pkg::PCRC_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      state <= pcrc_pkg::PCRC_IDLE;
    end
    else
    begin
      state <= next_state;
    end
  end

  // msb first, one bit a clock
  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      bitIndex <= 4'h0;
    end
    else if (pushWord && fifoFullFlag)
    begin
      bitIndex <= 4'h0;
    end
    else if (shiftNow)
    begin
      bitIndex <= popWord ? 4'h0 : bitIndex + 4'h1;
    end
  end

  // ----------------------------------------------------------------
  // storage and engine
  // ----------------------------------------------------------------
  pcrc_word_store #(
    .WIDTH(16),
    .DEPTH(16)
  ) u_store (
    .clk_sys(clk_sys),
    .rst_b(rst_b),
    .push(pushWord && !fifoFullFlag),
    .writeIndex(wrPtr),
    .writeWord(mergedWord),
    .readIndex(rdPtr),
    .readWord(headWord)
  );

  pcrc_engine u_engine (
    .clk_sys(clk_sys),
    .rst_b(rst_b),
    .shift(shiftNow),
    .dataBit(headWord[polyLenMinusOne - bitIndex]),
    .polyLenMinusOne(polyLenMinusOne),
    .taps(taps),
    .load(resultLoad),
    .loadValue(regWriteData),
    .crcValue(crcValue)
  );

  // ----------------------------------------------------------------
  // completion pulse
  // ----------------------------------------------------------------
  // only one to zero by draining; wrap never fires
  // raised while frozen only in the first frozen cycle, as it is registered
  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      crcDone <= 1'b0;
    end
    else
    begin
      crcDone <= popWord && !pushWord && (validWordCount == 5'h01);
    end
  end

  // ----------------------------------------------------------------
  // read port
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      regReadData <= 16'h0000;
    end
    else if (regRead)
    begin
      unique case (regAddr)
        `PCRC_ADDR_CONTROL: regReadData <= {2'b00, stopInIdle, validWordCount,
          fifoFullFlag, fifoEmptyFlag, 1'b0, shiftGo, polyLenMinusOne};
        `PCRC_ADDR_TAPS: regReadData <= taps;
        `PCRC_ADDR_DATA: regReadData <= crcValue;
        `PCRC_ADDR_RESULT: regReadData <= crcValue;
      endcase
    end
    else
    begin
      regReadData <= 16'h0000;
    end
  end
endmodule

// file: pcrc_monitor.sv
// checker for pcrc_top: register readback, flags and done pulse
// assumes read data stands only in the cycle after the read strobe
`timescale 1ns/1ps
`include "pcrc_cfg.svh"
module pcrc_monitor (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic [1:0] regAddr,
  input wire logic [15:0] regWriteData,
  input wire logic [1:0] regByteEn,
  input wire logic regWrite,
  input wire logic regRead,
  input wire logic sleepReq,
  input wire logic idleReq,
  input wire logic [15:0] regReadData,
  input wire logic crcDone
);
  logic [4:0] ctlLow;
  logic stopBit;
  logic [15:0] tapSh;
  logic rdAny;
  logic rdCtl;
  logic rdTap;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_b);
  // ----------------
  // shadow of writable bits
  // ----------------
  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      ctlLow <= 5'h00;
      stopBit <= 1'b0;
      tapSh <= 16'h0000;
    end
    else if (regWrite && regAddr == `PCRC_ADDR_CONTROL)
    begin
      if (regByteEn[0])
        ctlLow <= regWriteData[4:0];
      if (regByteEn[1])
        stopBit <= regWriteData[13];
    end
    else if (regWrite && regAddr == `PCRC_ADDR_TAPS)
      tapSh <= {regByteEn[1] ? regWriteData[15:8] : tapSh[15:8],
        regByteEn[0] ? regWriteData[7:0] : tapSh[7:0]};
  end
  // read strobes seen, one cycle late like the answer
  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      rdAny <= 1'b0;
      rdCtl <= 1'b0;
      rdTap <= 1'b0;
    end
    else
    begin
      rdAny <= regRead;
      rdCtl <= regRead && regAddr == `PCRC_ADDR_CONTROL;
      rdTap <= regRead && regAddr == `PCRC_ADDR_TAPS;
    end
  end
  // ----------------
  // properties
  // ----------------
  a_read_idle_zero: assert property (!rdAny |-> regReadData == 16'h0000)
    else $error("read data not zero outside answer cycle");
  a_ctrl_rw_bits: assert property (rdCtl |-> regReadData[4:0] == ctlLow
    && regReadData[13] == stopBit) else $error("control writable bits wrong");
  a_ctrl_unused_zero: assert property (rdCtl |-> regReadData[15:14] == 2'h0
    && !regReadData[5]) else $error("control unused bits not zero");
  a_taps_rw: assert property (rdTap |-> regReadData == {tapSh[15:1], 1'b0})
    else $error("taps readback wrong");
  a_empty_count: assert property (rdCtl |-> regReadData[6] == (regReadData[12:8] == 5'h00))
    else $error("empty flag disagrees with count");
  a_full_depth: assert property (rdCtl |-> regReadData[7] == (regReadData[12:8] ==
    (regReadData[3:0] > 4'h7 ? 5'h08 : 5'h10))) else $error("full flag disagrees with depth");
  a_done_single: assert property (crcDone |=> !crcDone)
    else $error("done pulse longer than one cycle");
  a_freeze_no_done: assert property (sleepReq [*3] |-> !crcDone)
    else $error("done pulse while frozen");
  c_done: cover property (crcDone);
  c_full_read: cover property (rdCtl && regReadData[7]);
  c_sleep_read: cover property (sleepReq && rdCtl);
endmodule
bind pcrc_top pcrc_monitor pcrc_monitor_inst (.clk_sys(clk_sys), .rst_b(rst_b),
  .regAddr(regAddr), .regWriteData(regWriteData), .regByteEn(regByteEn),
  .regWrite(regWrite), .regRead(regRead), .sleepReq(sleepReq), .idleReq(idleReq),
  .regReadData(regReadData), .crcDone(crcDone));

// file: tb.sv
// self-checking bench for pcrc_top: registers, crc results, fifo flags, freeze
// assumes pcrc_cfg.svh and the monitor compiled first
`timescale 1ns/1ps
`include "pcrc_cfg.svh"
module tb;
  logic clk_sys = 1'b0;
  logic rst_b = 1'b0;
  logic [1:0] regAddr = 2'h0;
  logic [15:0] regWriteData = 16'h0000;
  logic [1:0] regByteEn = 2'h0;
  logic regWrite = 1'b0;
  logic regRead = 1'b0;
  logic sleepReq = 1'b0;
  logic idleReq = 1'b0;
  logic [15:0] regReadData;
  logic crcDone;
  logic rdSeen = 1'b0;
  logic [31:0] pair;
  logic [31:0] expQ[$];
  logic [15:0] lfsr = 16'h004c;
  int miscompares = 0;
  int nTests = 0;
  int doneCnt = 0;
  int cyc = 0;
  pcrc_top pcrc_top_inst (.clk_sys(clk_sys), .rst_b(rst_b), .regAddr(regAddr),
    .regWriteData(regWriteData), .regByteEn(regByteEn), .regWrite(regWrite),
    .regRead(regRead), .sleepReq(sleepReq), .idleReq(idleReq),
    .regReadData(regReadData), .crcDone(crcDone));
  always #20 clk_sys = ~clk_sys;
  // ----------------
  // checking and closing
  // ----------------
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    nTests++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic complete_run();
    $display("compares %0d miscompares %0d", nTests, miscompares);
    if (miscompares == 0 && nTests > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  always @(posedge clk_sys)
  begin
    rdSeen <= regRead;
    cyc <= cyc + 1;
    if (crcDone === 1'b1)
      doneCnt <= doneCnt + 1;
    if (cyc == 20000)
    begin
      miscompares++;
      complete_run();
    end
  end
  // oldest note pairs with each answer
  always @(negedge clk_sys)
    if (rdSeen)
    begin
      pair = expQ.pop_front();
      check(regReadData & pair[31:16], pair[15:0]);
    end
  // ----------------
  // bus, stimulus and model
  // ----------------
  task automatic wr(input logic [1:0] a, input logic [15:0] d, input logic [1:0] b);
    regAddr <= a;
    regWriteData <= d;
    regByteEn <= b;
    regWrite <= 1'b1;
    @(posedge clk_sys);
    regWrite <= 1'b0;
    @(posedge clk_sys);
  endtask
  task automatic rd(input logic [1:0] a, input logic [15:0] e, input logic [15:0] m);
    expQ.push_back({m, e & m});
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge clk_sys);
    regRead <= 1'b0;
    @(posedge clk_sys);
  endtask
  function automatic logic [15:0] nxt(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  function automatic logic [15:0] ctl(input logic [4:0] n, input logic go,
      input logic stop, input logic [3:0] len);
    return {2'h0, stop, n, n == (len > 4'h7 ? 5'h08 : 5'h10), n == 5'h00, 1'b0, go, len};
  endfunction
  function automatic logic [15:0] step(input logic [15:0] c, input logic [15:0] w,
      input logic [3:0] len, input logic [15:0] tp);
    logic [15:0] m;
    logic fb;
    m = 16'hffff >> (4'hf - len);
    for (int i = 15; i >= 0; i--)
      if (i <= int'(len))
      begin
        fb = c[len] ^ w[i];
        c = (c << 1) & m;
        if (fb)
          c = c ^ (tp & m) ^ 16'h0001;
      end
    return c;
  endfunction
  // mode 1 sleep, 2 idle with stop, 3 idle without stop
  task automatic run(input logic [3:0] len, input logic [4:0] n, input int mode);
    logic [15:0] m;
    logic [15:0] tp;
    logic [15:0] w;
    logic [15:0] c;
    logic st;
    logic ok;
    int t0;
    int d0;
    int nw;
    m = 16'hffff >> (4'hf - len);
    st = mode == 2;
    nw = int'(n) + ((mode == 3) ? 1 : 0);
    lfsr = nxt(lfsr);
    tp = lfsr & m & 16'hfffe;
    c = 16'h0000;
    wr(`PCRC_ADDR_TAPS, tp, 2'h3);
    wr(`PCRC_ADDR_CONTROL, {2'h0, st, 9'h000, len}, 2'h3);
    wr(`PCRC_ADDR_RESULT, 16'h0000, 2'h3);
    for (int k = 0; k < int'(n); k++)
    begin
      lfsr = nxt(lfsr);
      w = lfsr & m;
      c = step(c, w, len, tp);
      if (len > 4'h7 && len < 4'hf)
      begin
        wr(`PCRC_ADDR_DATA, w, 2'h1);
        wr(`PCRC_ADDR_DATA, w, 2'h2);
      end
      else
        wr(`PCRC_ADDR_DATA, w, len > 4'h7 ? 2'h3 : 2'h1);
    end
    rd(`PCRC_ADDR_CONTROL, ctl(n, 1'b0, st, len), 16'hffff);
    sleepReq <= mode == 1;
    idleReq <= mode >= 2;
    d0 = doneCnt;
    t0 = cyc;
    wr(`PCRC_ADDR_CONTROL, {2'h0, st, 8'h00, 1'b1, len}, 2'h3);
    if (mode == 3)
    begin
      rd(`PCRC_ADDR_CONTROL, ctl(n, 1'b1, st, len), 16'hffff);
      lfsr = nxt(lfsr);
      w = lfsr & m;
      c = step(c, w, len, tp);
      wr(`PCRC_ADDR_DATA, w, 2'h1);
      rd(`PCRC_ADDR_CONTROL, ctl(n, 1'b1, st, len), 16'hffff);
    end
    if (mode == 1 || mode == 2)
    begin
      repeat (60) @(posedge clk_sys);
      rd(`PCRC_ADDR_CONTROL, ctl(n, 1'b1, st, len), 16'hffff);
      sleepReq <= 1'b0;
      idleReq <= 1'b0;
    end
    for (int i = 0; i < 600 && doneCnt == d0; i++)
      @(posedge clk_sys);
    ok = (cyc - t0) >= (int'(len) + 1) * nw && (cyc - t0) <= (int'(len) + 1) * nw + 8;
    if (mode == 0 || mode == 3)
      check({15'h0000, ok}, 16'h0001);
    check(16'(doneCnt - d0), 16'h0001);
    rd(`PCRC_ADDR_CONTROL, ctl(5'h00, 1'b1, st, len), 16'hffff);
    rd(`PCRC_ADDR_RESULT, c, m);
    rd(`PCRC_ADDR_DATA, c, m);
    wr(`PCRC_ADDR_CONTROL, {12'h000, len}, 2'h3);
    idleReq <= 1'b0;
  endtask
  task automatic fill(input logic [3:0] len, input logic [4:0] d);
    int d0;
    wr(`PCRC_ADDR_CONTROL, {12'h000, len}, 2'h3);
    for (int k = 0; k < int'(d); k++)
      wr(`PCRC_ADDR_DATA, 16'h00a5, 2'h3);
    rd(`PCRC_ADDR_CONTROL, ctl(d, 1'b0, 1'b0, len), 16'hffff);
    wr(`PCRC_ADDR_DATA, 16'h005a, 2'h3);
    rd(`PCRC_ADDR_CONTROL, ctl(5'h00, 1'b0, 1'b0, len), 16'hffff);
    d0 = doneCnt;
    wr(`PCRC_ADDR_CONTROL, {11'h000, 1'b1, len}, 2'h3);
    repeat (40) @(posedge clk_sys);
    check(16'(doneCnt - d0), 16'h0000);
    wr(`PCRC_ADDR_CONTROL, {12'h000, len}, 2'h3);
  endtask
  // ----------------
  // main sequence
  // ----------------
  initial
  begin
    repeat (8) @(posedge clk_sys);
    rst_b <= 1'b1;
    @(posedge clk_sys);
    rd(`PCRC_ADDR_CONTROL, 16'h0040, 16'hffff);
    rd(`PCRC_ADDR_TAPS, 16'h0000, 16'hffff);
    wr(`PCRC_ADDR_TAPS, 16'hffff, 2'h3);
    rd(`PCRC_ADDR_TAPS, 16'hfffe, 16'hffff);
    run(4'hf, 5'h03, 0);
    run(4'h7, 5'h04, 1);
    run(4'hc, 5'h02, 2);
    run(4'h3, 5'h05, 3);
    run(4'h0, 5'h02, 0);
    fill(4'h8, 5'h08);
    fill(4'h7, 5'h10);
    repeat (2) @(posedge clk_sys);
    complete_run();
  end
endmodule
